// ===== bpp_pkg.sv
// constants shared by the parallel port block
package bpp_pkg;

    // ************************************************************
    // port widths
    // ************************************************************
    localparam int BPP_WIDTH_A = 8;
    localparam int BPP_WIDTH_B = 8;
    localparam int BPP_WIDTH_C = 4;
    localparam int BPP_TOTAL_LINES = 20;
    localparam int BPP_SYNC_STAGES = 2;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam int BPP_ADDR_W = 12;
    localparam logic [11:0] BPP_OFS_DATA_A = 12'h000;
    localparam logic [11:0] BPP_OFS_DATA_B = 12'h004;
    localparam logic [11:0] BPP_OFS_DATA_C = 12'h008;
    localparam logic [11:0] BPP_OFS_DIR_A = 12'h00C;
    localparam logic [11:0] BPP_OFS_DIR_B = 12'h010;
    localparam logic [11:0] BPP_OFS_DIR_C = 12'h014;

    // ************************************************************
    // values after reset and the direction read-back value
    // ************************************************************
    localparam logic [7:0] BPP_DIR_RESET = 8'h00;
    localparam logic [31:0] BPP_RDATA_RESET = 32'h0000_0000;
    localparam logic [31:0] BPP_DIR_READ = 32'hFFFF_FFFF;

endpackage : bpp_pkg

// ===== bpp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bpp_sync
    import bpp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ************************************************************
    // metastability stages
    // ************************************************************
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    initial begin
        if (WIDTH < 1) begin
            $error("bpp_sync: WIDTH must be at least 1");
        end
    end

    always_comb begin
        meta_nxt = async_in;
        // only the second stage reads the first
        sync_nxt = meta_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;

endmodule : bpp_sync

// ===== bpp_ports.sv
// three bidirectional parallel ports behind an apb slave
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Operation
// - direction 1 drives latch, 0 makes input
// - direction registers read back all ones
// - reset clears every direction bit
// - reset leaves output data latches untouched
// - data write updates every latch bit
// - output line reads back its latch
// - input line reads synchronised pin level
// - input line driver off, port a optional
// - two byte ports, one nibble port
// - port a optional build-time pull-up
module bpp_ports
    import bpp_pkg::*;
#(
    parameter int WIDTH_A = BPP_WIDTH_A,
    parameter int WIDTH_B = BPP_WIDTH_B,
    parameter int WIDTH_C = BPP_WIDTH_C,
    parameter bit PULLUP_A = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [BPP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // first byte port
    input wire logic [WIDTH_A-1:0] first_byte_port_lines_in,
    output logic [WIDTH_A-1:0] first_byte_port_lines_out,
    output logic [WIDTH_A-1:0] first_byte_port_lines_oe,
    output logic [WIDTH_A-1:0] first_byte_port_pullup_en,
    // second byte port
    input wire logic [WIDTH_B-1:0] second_byte_port_lines_in,
    output logic [WIDTH_B-1:0] second_byte_port_lines_out,
    output logic [WIDTH_B-1:0] second_byte_port_lines_oe,
    // nibble port
    input wire logic [WIDTH_C-1:0] nibble_port_lines_in,
    output logic [WIDTH_C-1:0] nibble_port_lines_out,
    output logic [WIDTH_C-1:0] nibble_port_lines_oe
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    initial begin
        if (WIDTH_A < 1 || WIDTH_A > 8 || WIDTH_B < 1 || WIDTH_B > 8 ||
            WIDTH_C < 1 || WIDTH_C > 8) begin
            $error("bpp_ports: each port must be 1 to 8 lines wide");
        end
        if (WIDTH_A + WIDTH_B + WIDTH_C != BPP_TOTAL_LINES) begin
            $error("bpp_ports: ports must total the documented lines");
        end
    end

    // ************************************************************
    // bus decode
    // ************************************************************
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic hit_da;
    logic hit_db;
    logic hit_dc;
    logic hit_ra;
    logic hit_rb;
    logic hit_rc;
    logic mapped;

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    // a write lands only at the edge that completes the access
    assign wr_en = access_ph & pwrite & pstrb[0];
    assign hit_da = (paddr == BPP_OFS_DATA_A);
    assign hit_db = (paddr == BPP_OFS_DATA_B);
    assign hit_dc = (paddr == BPP_OFS_DATA_C);
    assign hit_ra = (paddr == BPP_OFS_DIR_A);
    assign hit_rb = (paddr == BPP_OFS_DIR_B);
    assign hit_rc = (paddr == BPP_OFS_DIR_C);
    assign mapped = hit_da | hit_db | hit_dc | hit_ra | hit_rb | hit_rc;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [WIDTH_A-1:0] pin_a;
    logic [WIDTH_B-1:0] pin_b;
    logic [WIDTH_C-1:0] pin_c;

    bpp_sync #(.WIDTH(WIDTH_A)) u_sync_a (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(first_byte_port_lines_in),
        .sync_out(pin_a)
    );

    bpp_sync #(.WIDTH(WIDTH_B)) u_sync_b (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(second_byte_port_lines_in),
        .sync_out(pin_b)
    );

    bpp_sync #(.WIDTH(WIDTH_C)) u_sync_c (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(nibble_port_lines_in),
        .sync_out(pin_c)
    );

    // ************************************************************
    // direction registers
    // ************************************************************
    logic [WIDTH_A-1:0] dir_a_r;
    logic [WIDTH_A-1:0] dir_a_nxt;
    logic [WIDTH_B-1:0] dir_b_r;
    logic [WIDTH_B-1:0] dir_b_nxt;
    logic [WIDTH_C-1:0] dir_c_r;
    logic [WIDTH_C-1:0] dir_c_nxt;

    always_comb begin
        dir_a_nxt = dir_a_r;
        dir_b_nxt = dir_b_r;
        dir_c_nxt = dir_c_r;
        if (wr_en && hit_ra) begin
            dir_a_nxt = pwdata[WIDTH_A-1:0];
        end
        if (wr_en && hit_rb) begin
            dir_b_nxt = pwdata[WIDTH_B-1:0];
        end
        if (wr_en && hit_rc) begin
            dir_c_nxt = pwdata[WIDTH_C-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_a_r <= BPP_DIR_RESET[WIDTH_A-1:0];
            dir_b_r <= BPP_DIR_RESET[WIDTH_B-1:0];
            dir_c_r <= BPP_DIR_RESET[WIDTH_C-1:0];
        end else begin
            dir_a_r <= dir_a_nxt;
            dir_b_r <= dir_b_nxt;
            dir_c_r <= dir_c_nxt;
        end
    end

    // ************************************************************
    // output data latches
    // ************************************************************
    logic [WIDTH_A-1:0] out_a_r;
    logic [WIDTH_A-1:0] out_a_nxt;
    logic [WIDTH_B-1:0] out_b_r;
    logic [WIDTH_B-1:0] out_b_nxt;
    logic [WIDTH_C-1:0] out_c_r;
    logic [WIDTH_C-1:0] out_c_nxt;

    // whole port is written whatever the directions are
    always_comb begin
        out_a_nxt = out_a_r;
        out_b_nxt = out_b_r;
        out_c_nxt = out_c_r;
        if (wr_en && hit_da) begin
            out_a_nxt = pwdata[WIDTH_A-1:0];
        end
        if (wr_en && hit_db) begin
            out_b_nxt = pwdata[WIDTH_B-1:0];
        end
        if (wr_en && hit_dc) begin
            out_c_nxt = pwdata[WIDTH_C-1:0];
        end
    end

    // no reset here: contents survive reset and start undefined
    always_ff @(posedge pclk) begin
        out_a_r <= out_a_nxt;
        out_b_r <= out_b_nxt;
        out_c_r <= out_c_nxt;
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    assign first_byte_port_lines_out = out_a_r;
    assign second_byte_port_lines_out = out_b_r;
    assign nibble_port_lines_out = out_c_r;
    assign first_byte_port_lines_oe = dir_a_r;
    assign second_byte_port_lines_oe = dir_b_r;
    assign nibble_port_lines_oe = dir_c_r;
    // pull-up only holds an input line; without the option it floats
    assign first_byte_port_pullup_en =
        PULLUP_A ? ~dir_a_r : '0;

    // ************************************************************
    // read data and answer
    // ************************************************************
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;

    // read data is captured at the setup edge so it leaves a flip-flop
    always_comb begin
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup_ph) begin
            prdata_nxt = BPP_RDATA_RESET;
            pslverr_nxt = ~mapped;
            if (!pwrite) begin
                if (hit_da) begin
                    prdata_nxt[WIDTH_A-1:0] =
                        (dir_a_r & out_a_r) | (~dir_a_r & pin_a);
                end
                if (hit_db) begin
                    prdata_nxt[WIDTH_B-1:0] =
                        (dir_b_r & out_b_r) | (~dir_b_r & pin_b);
                end
                if (hit_dc) begin
                    prdata_nxt[WIDTH_C-1:0] =
                        (dir_c_r & out_c_r) | (~dir_c_r & pin_c);
                end
                if (hit_ra) begin
                    prdata_nxt[WIDTH_A-1:0] = BPP_DIR_READ[WIDTH_A-1:0];
                end
                if (hit_rb) begin
                    prdata_nxt[WIDTH_B-1:0] = BPP_DIR_READ[WIDTH_B-1:0];
                end
                if (hit_rc) begin
                    prdata_nxt[WIDTH_C-1:0] = BPP_DIR_READ[WIDTH_C-1:0];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= BPP_RDATA_RESET;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    // access phase always completes in its first cycle
    assign pready = 1'b1;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic rd_setup;
    assign rd_setup = setup_ph & ~pwrite;

    AST_DIR_DRIVES: assert property (
        (wr_en && hit_rb) |=> (second_byte_port_lines_oe ==
            $past(pwdata[WIDTH_B-1:0])) &&
            $stable(second_byte_port_lines_out)
    ) else $error("direction write did not reach the drivers");

    AST_DIR_READS_ONES: assert property (
        (rd_setup && hit_rc) |=> penable |->
            (prdata[WIDTH_C-1:0] == BPP_DIR_READ[WIDTH_C-1:0])
    ) else $error("direction read did not return ones");

    AST_RESET_INPUTS: assert property (
        $rose(presetn) |-> (first_byte_port_lines_oe == '0) &&
            (second_byte_port_lines_oe == '0) &&
            (nibble_port_lines_oe == '0)
    ) else $error("a line drives right after reset");

    AST_LATCH_HOLDS: assert property (
        // latch starts unknown, so look for a change and ask for its cause
        $changed(first_byte_port_lines_out) |-> $past(wr_en && hit_da)
    ) else $error("port latch changed without a write");

    AST_DATA_WRITE_ALL: assert property (
        (wr_en && hit_dc) |=>
            (nibble_port_lines_out == $past(pwdata[WIDTH_C-1:0]))
    ) else $error("data write missed some latch bits");

    AST_OUTPUT_READBACK: assert property (
        (rd_setup && hit_da && (dir_a_r == '1)) |=>
            (prdata[WIDTH_A-1:0] == first_byte_port_lines_out)
    ) else $error("output line did not read back its latch");

    AST_INPUT_READBACK: assert property (
        (rd_setup && hit_db) |=>
            ((prdata[WIDTH_B-1:0] & ~$past(dir_b_r)) ==
            ($past(pin_b) & ~$past(dir_b_r)))
    ) else $error("input line did not read the pin");

    AST_INPUT_FLOATS: assert property (
        (wr_en && hit_ra) |=> ((first_byte_port_lines_oe &
            ~$past(pwdata[WIDTH_A-1:0])) == '0) &&
            (first_byte_port_pullup_en ==
            (PULLUP_A ? ~$past(pwdata[WIDTH_A-1:0]) : '0))
    ) else $error("input line still driven");

    AST_WRITE_TIMING: assert property (
        (setup_ph && pwrite && hit_rc) |=> $stable(nibble_port_lines_oe)
    ) else $error("direction changed before the access edge");

    AST_UNMAPPED_ERR: assert property (
        (setup_ph && !mapped) |=> pslverr && (prdata == BPP_RDATA_RESET)
    ) else $error("unmapped address not answered with an error");

    COV_DATA_WRITE: cover property (wr_en && hit_db);
    COV_DIR_OUT: cover property ((wr_en && hit_ra) ##1 (dir_a_r != '0));
    COV_PIN_READ: cover property (rd_setup && hit_dc && (dir_c_r == '0));
    COV_UNMAPPED: cover property (setup_ph && !mapped);

endmodule : bpp_ports

// ===== bpp_board_model.sv
// board circuitry model standing on one parallel port
`timescale 1ns/1ps
module bpp_board_model #(
    parameter int W = 8
) (
    // lines from the port
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    // board side
    input wire logic [W-1:0] ext,
    input wire logic fight,
    output logic [W-1:0] pin
);
    // a heavy load may drag a driven line to the other level
    always_comb begin
        pin = (oe & (out ^ {W{fight}})) | (~oe & ext);
    end
endmodule : bpp_board_model

// ===== test_bidirectional_parallel_ports.sv
// self-checking bench for the parallel port block
`timescale 1ns/1ps
module test_bidirectional_parallel_ports;
    import bpp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] ext_a = 8'h00;
    logic [7:0] ext_b = 8'h00;
    logic [3:0] ext_c = 4'h0;
    logic fight = 1'b0;
    logic [7:0] pin_a, out_a, oe_a, pu_a, pin_b, out_b, oe_b;
    logic [3:0] pin_c, out_c, oe_c;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int checks_done = 0;

    always #5 pclk = ~pclk;

    bpp_ports dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .first_byte_port_lines_in(pin_a),
        .first_byte_port_lines_out(out_a),
        .first_byte_port_lines_oe(oe_a),
        .first_byte_port_pullup_en(pu_a),
        .second_byte_port_lines_in(pin_b),
        .second_byte_port_lines_out(out_b),
        .second_byte_port_lines_oe(oe_b),
        .nibble_port_lines_in(pin_c),
        .nibble_port_lines_out(out_c),
        .nibble_port_lines_oe(oe_c));
    bpp_board_model #(.W(8)) brd_a (.out(out_a), .oe(oe_a), .ext(ext_a),
        .fight(fight), .pin(pin_a));
    bpp_board_model #(.W(8)) brd_b (.out(out_b), .oe(oe_b), .ext(ext_b),
        .fight(fight), .pin(pin_b));
    bpp_board_model #(.W(4)) brd_c (.out(out_c), .oe(oe_c), .ext(ext_c),
        .fight(fight), .pin(pin_c));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        chk({oe_c, oe_b, oe_a}, 32'h0);
        chk(pu_a, 32'h0);
        // only the port's own bits read as ones, upper bits read zero
        apb(1'b0, BPP_OFS_DIR_A, 32'h0, 4'hF); chk(rd, 32'hFF);
        apb(1'b0, BPP_OFS_DIR_C, 32'h0, 4'hF); chk(rd, 32'hF);
    endtask : t_reset

    task automatic t_write;
        // data first, so no line ever drives an unknown
        apb(1'b1, BPP_OFS_DATA_A, 32'hA5, 4'hF);
        apb(1'b1, BPP_OFS_DATA_B, 32'h3C, 4'hF);
        apb(1'b1, BPP_OFS_DATA_C, 32'h9, 4'hF);
        chk({out_c, out_b, out_a}, 32'h93CA5);
        chk(oe_a, 32'h0);
        apb(1'b1, BPP_OFS_DIR_A, 32'hFF, 4'hF);
        chk(oe_a, 32'hFF);
        apb(1'b1, BPP_OFS_DIR_B, 32'hF0, 4'hF);
        apb(1'b1, BPP_OFS_DIR_C, 32'h3, 4'hF);
        chk({oe_c, oe_b}, 32'h3F0);
        apb(1'b0, BPP_OFS_DIR_B, 32'h0, 4'hF); chk(rd, 32'hFF);
    endtask : t_write

    task automatic t_read;
        @(posedge pclk);
        fight <= 1'b1;
        ext_b <= 8'h0A;
        ext_c <= 4'hC;
        repeat (3) @(posedge pclk);
        apb(1'b0, BPP_OFS_DATA_A, 32'h0, 4'hF); chk(rd, 32'hA5);
        apb(1'b0, BPP_OFS_DATA_B, 32'h0, 4'hF); chk(rd, 32'h3A);
        apb(1'b0, BPP_OFS_DATA_C, 32'h0, 4'hF); chk(rd, 32'hD);
    endtask : t_read

    task automatic t_refuse;
        @(posedge pclk);
        fight <= 1'b0;
        apb(1'b1, BPP_OFS_DATA_A, 32'h00, 4'h0);
        chk(out_a, 32'hA5);
        apb(1'b0, 12'h018, 32'h0, 4'hF);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, BPP_OFS_DATA_C, 32'hFFFF_FFFF, 4'hF);
        apb(1'b0, BPP_OFS_DATA_C, 32'h0, 4'hF); chk(rd, 32'hF);
    endtask : t_refuse

    task automatic t_rereset;
        // high nibble of port a back to input
        apb(1'b1, BPP_OFS_DIR_A, 32'h0F, 4'hF);
        chk(oe_a, 32'h0F);
        chk(pu_a, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({oe_c, oe_b, oe_a}, 32'h0);
        chk({out_c, out_b, out_a}, 32'hF3CA5);
        presetn <= 1'b1;
        // synchronisers restart from zero, give the pins two edges
        repeat (2) @(posedge pclk);
        apb(1'b0, BPP_OFS_DATA_B, 32'h0, 4'hF); chk(rd, 32'h0A);
        apb(1'b0, BPP_OFS_DATA_C, 32'h0, 4'hF); chk(rd, 32'hC);
        chk({out_c, out_b, out_a}, 32'hF3CA5);
    endtask : t_rereset

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset();
        t_write();
        t_read();
        t_refuse();
        t_rereset();
        end_sim();
    end

    initial begin
        #20000;
        fails++;
        end_sim();
    end
endmodule : test_bidirectional_parallel_ports
